/* File: hdl/bnk1_pkg.sv */
// Purpose: constants and types for the bank-one register file
// Assumes: register index = AXI byte address / 4
// Notes: arrays are indexed by the low five index bits
package bnk1_pkg;
  // ---------------------------------------------------------------
  // register indices
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_INDIRECT = 8'h80;
  localparam logic [7:0] IDX_OPTION = 8'h81;
  localparam logic [7:0] IDX_PCL = 8'h82;
  localparam logic [7:0] IDX_STATUS = 8'h83;
  localparam logic [7:0] IDX_POINTER = 8'h84;
  localparam logic [7:0] IDX_DIR_A = 8'h85;
  localparam logic [7:0] IDX_DIR_B = 8'h86;
  localparam logic [7:0] IDX_DIR_C = 8'h87;
  localparam logic [7:0] IDX_DIR_D = 8'h88;
  localparam logic [7:0] IDX_DIR_E = 8'h89;
  localparam logic [7:0] IDX_PCLATCH = 8'h8a;
  localparam logic [7:0] IDX_INTCTL = 8'h8b;
  localparam logic [7:0] IDX_PIE_ONE = 8'h8c;
  localparam logic [7:0] IDX_PIE_TWO = 8'h8d;
  localparam logic [7:0] IDX_POWER = 8'h8e;
  localparam logic [7:0] IDX_T2PERIOD = 8'h92;
  localparam logic [7:0] IDX_SSP_ADDR = 8'h93;
  localparam logic [7:0] IDX_SSP_STAT = 8'h94;
  localparam logic [7:0] IDX_TX_CTRL = 8'h98;
  localparam logic [7:0] IDX_BAUD = 8'h99;
  localparam logic [2:0] BANK1_TOP = 3'h4;
  localparam int ADDR_W = 10;
  // ---------------------------------------------------------------
  // decode maps, one bit per low index
  // ---------------------------------------------------------------
  localparam logic [31:0] IMPL_MAP = 32'h031C_7FFF;
  localparam logic [31:0] COMMON_MAP = 32'h0000_0C1D;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_TO = 4;
  localparam int BIT_IBOV = 5;
  localparam int BIT_IBF = 7;
  localparam int BIT_OBF = 6;
  localparam int BIT_TRMT = 1;
  localparam int BIT_WSTRB0 = 0;
  localparam int PCU_W = 5;
  // ---------------------------------------------------------------
  // per-register masks and values
  // ---------------------------------------------------------------
  // software-writable bits; zero also for unimplemented locations
  localparam logic [7:0] WR_MASK [32] = '{
    8'h00, 8'hff, 8'hff, 8'he7, 8'hff, 8'h3f, 8'hff, 8'hff,
    8'hff, 8'h37, 8'h1f, 8'hff, 8'hff, 8'h01, 8'h03, 8'h00,
    8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hf5, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // power-on / brown-out values
  localparam logic [7:0] PWR_VAL [32] = '{
    8'h00, 8'hff, 8'h00, 8'h18, 8'h00, 8'h3f, 8'hff, 8'hff,
    8'hff, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // bits left unchanged by the other resets, except TO, which a watchdog reset clears
  localparam logic [7:0] KEEP_MASK [32] = '{
    8'h00, 8'h00, 8'h00, 8'h1f, 8'hff, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h03, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [1:0] RESP_OKAY = 2'h0;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] option;
    logic [7:0] status;
    logic [7:0] pointer;
    logic [7:0] dirA;
    logic [7:0] dirB;
    logic [7:0] dirC;
    logic [7:0] dirD;
    logic [7:0] dirE;
    logic [7:0] pcLatch;
    logic [7:0] intCtl;
    logic [7:0] pieOne;
    logic [7:0] pieTwo;
    logic [7:0] power;
    logic [7:0] t2Period;
    logic [7:0] sspAddr;
    logic [7:0] txCtrl;
    logic [7:0] baud;
  } bnk1_cfg_t;
  typedef enum logic {WR_IDLE, WR_RESP} bnk1_wr_t;
  typedef enum logic {RD_IDLE, RD_DATA} bnk1_rd_t;
endpackage : bnk1_pkg

/* File: hdl/bnk1_sfr_bank.sv */
// Purpose: bank-one special register file behind an AXI4-Lite slave
// Assumes: resets other than power-on arrive as one-cycle pulses
// Notes: all registers answer OKAY; byte lane 0 carries the data
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module bnk1_sfr_bank (
  input wire logic clk,
  input wire logic rst,
  input wire logic extResetPulse,
  input wire logic wdtResetPulse,
  input wire logic pcLoad,
  input wire logic [7:0] indirRdData,
  input wire logic pspInFull,
  input wire logic pspOutFull,
  input wire logic pspOverflowEvt,
  input wire logic [5:0] sspStatusIn,
  input wire logic txShiftEmpty,
  input wire logic [bnk1_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [bnk1_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output bnk1_pkg::bnk1_cfg_t cfg,
  output logic [bnk1_pkg::PCU_W-1:0] pcUpper,
  output logic indirWrStrobe,
  output logic [7:0] indirWrData
);
  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // returns {hit, low index}; bank-zero alias only for common registers
  function automatic logic [5:0] mapAddr(input logic [bnk1_pkg::ADDR_W-1:0] a);
    logic [7:0] idx;
    logic hit;
    idx = a[bnk1_pkg::ADDR_W-1:2];
    hit = 1'b0;
    if (idx[7:5] == bnk1_pkg::BANK1_TOP) begin
      hit = bnk1_pkg::IMPL_MAP[idx[4:0]];
    end else if (idx[7:5] == 3'h0) begin
      hit = bnk1_pkg::COMMON_MAP[idx[4:0]];
    end
    return {hit, idx[4:0]};
  endfunction : mapAddr

  logic [7:0] mem_reg [32];
  logic [7:0] memNext [32];
  logic [bnk1_pkg::PCU_W-1:0] pcUpper_reg;
  logic [bnk1_pkg::PCU_W-1:0] pcUpper_next;
  logic indirWr_reg;
  logic indirWr_next;
  logic [7:0] indirData_reg;
  logic [7:0] indirData_next;

  // ---------------------------------------------------------------
  // write channel
  // ---------------------------------------------------------------
  bnk1_pkg::bnk1_wr_t wrState_reg;
  bnk1_pkg::bnk1_wr_t wrState_next;
  logic awHave_reg;
  logic awHave_next;
  logic wHave_reg;
  logic wHave_next;
  logic [bnk1_pkg::ADDR_W-1:0] awAddr_reg;
  logic [bnk1_pkg::ADDR_W-1:0] awAddr_next;
  logic [7:0] wData_reg;
  logic [7:0] wData_next;
  logic wLane_reg;
  logic wLane_next;
  logic doWrite;
  logic [5:0] wMap;

  assign s_axi_awready = !awHave_reg && (wrState_reg == bnk1_pkg::WR_IDLE);
  assign s_axi_wready = !wHave_reg && (wrState_reg == bnk1_pkg::WR_IDLE);
  assign s_axi_bvalid = (wrState_reg == bnk1_pkg::WR_RESP);
  assign s_axi_bresp = bnk1_pkg::RESP_OKAY;
  assign doWrite = awHave_reg && wHave_reg;
  assign wMap = mapAddr(awAddr_reg);

  always_comb begin
    wrState_next = wrState_reg;
    awHave_next = awHave_reg;
    wHave_next = wHave_reg;
    awAddr_next = awAddr_reg;
    wData_next = wData_reg;
    wLane_next = wLane_reg;
    case (wrState_reg)
      bnk1_pkg::WR_IDLE: begin
        if (s_axi_awvalid && s_axi_awready) begin
          awHave_next = 1'b1;
          awAddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          wHave_next = 1'b1;
          wData_next = s_axi_wdata[7:0];
          wLane_next = s_axi_wstrb[bnk1_pkg::BIT_WSTRB0];
        end
        if (doWrite) begin
          awHave_next = 1'b0;
          wHave_next = 1'b0;
          wrState_next = bnk1_pkg::WR_RESP;
        end
      end
      bnk1_pkg::WR_RESP: begin
        if (s_axi_bready) begin
          wrState_next = bnk1_pkg::WR_IDLE;
        end
      end
      default: begin
        wrState_next = bnk1_pkg::WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrState_reg <= bnk1_pkg::WR_IDLE;
      awHave_reg <= 1'b0;
      wHave_reg <= 1'b0;
      awAddr_reg <= '0;
      wData_reg <= 8'h00;
      wLane_reg <= 1'b0;
    end else begin
      wrState_reg <= wrState_next;
      awHave_reg <= awHave_next;
      wHave_reg <= wHave_next;
      awAddr_reg <= awAddr_next;
      wData_reg <= wData_next;
      wLane_reg <= wLane_next;
    end
  end

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic swWr;
  logic [4:0] wIdx;
  logic otherRst;

  assign wIdx = wMap[4:0];
  assign swWr = doWrite && wMap[5] && wLane_reg;
  assign otherRst = extResetPulse || wdtResetPulse;

  always_comb begin
    memNext = mem_reg;
    pcUpper_next = pcUpper_reg;
    indirWr_next = 1'b0;
    indirData_next = indirData_reg;
    if (otherRst) begin
      for (int i = 0; i < 32; i++) begin
        memNext[i] = (mem_reg[i] & bnk1_pkg::KEEP_MASK[i])
                   | (bnk1_pkg::PWR_VAL[i] & ~bnk1_pkg::KEEP_MASK[i]);
      end
      // watchdog time-out shows in the status word; pin reset leaves it
      if (wdtResetPulse) begin
        memNext[bnk1_pkg::IDX_STATUS[4:0]][bnk1_pkg::BIT_TO] = 1'b0;
      end
      pcUpper_next = '0;
    end else begin
      if (swWr) begin
        // masked merge keeps absent bits at zero
        memNext[wIdx] = (mem_reg[wIdx] & ~bnk1_pkg::WR_MASK[wIdx])
                      | (wData_reg & bnk1_pkg::WR_MASK[wIdx]);
        if (wIdx == bnk1_pkg::IDX_INDIRECT[4:0]) begin
          indirWr_next = 1'b1;
          indirData_next = wData_reg;
        end
      end
      // upper counter bits come only from the latch, never from the bus
      if (pcLoad || (swWr && wIdx == bnk1_pkg::IDX_PCL[4:0])) begin
        pcUpper_next = mem_reg[bnk1_pkg::IDX_PCLATCH[4:0]][bnk1_pkg::PCU_W-1:0];
      end
    end
    // overflow set placed last so it beats a same-cycle clear
    if (pspOverflowEvt) begin
      memNext[bnk1_pkg::IDX_DIR_E[4:0]][bnk1_pkg::BIT_IBOV] = 1'b1;
    end
  end

  for (genvar g = 0; g < 32; g++) begin : gMem
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        mem_reg[g] <= bnk1_pkg::PWR_VAL[g];
      end else begin
        mem_reg[g] <= memNext[g];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pcUpper_reg <= '0;
      indirWr_reg <= 1'b0;
      indirData_reg <= 8'h00;
    end else begin
      pcUpper_reg <= pcUpper_next;
      indirWr_reg <= indirWr_next;
      indirData_reg <= indirData_next;
    end
  end

  assign pcUpper = pcUpper_reg;
  assign indirWrStrobe = indirWr_reg;
  assign indirWrData = indirData_reg;

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  bnk1_pkg::bnk1_rd_t rdState_reg;
  bnk1_pkg::bnk1_rd_t rdState_next;
  logic [7:0] rData_reg;
  logic [7:0] rData_next;
  logic [5:0] rMap;
  logic [7:0] rVal;
  logic [7:0] rawVal;

  assign rMap = mapAddr(s_axi_araddr);
  assign rawVal = mem_reg[rMap[4:0]];
  assign s_axi_arready = (rdState_reg == bnk1_pkg::RD_IDLE);
  assign s_axi_rvalid = (rdState_reg == bnk1_pkg::RD_DATA);
  assign s_axi_rresp = bnk1_pkg::RESP_OKAY;
  assign s_axi_rdata = {24'h00_0000, rData_reg};

  always_comb begin
    rVal = 8'h00;
    if (rMap[5]) begin
      case (rMap[4:0])
        bnk1_pkg::IDX_INDIRECT[4:0]: begin
          rVal = indirRdData;
        end
        bnk1_pkg::IDX_SSP_STAT[4:0]: begin
          rVal = {2'b00, sspStatusIn};
        end
        bnk1_pkg::IDX_DIR_E[4:0]: begin
          rVal = rawVal;
          rVal[bnk1_pkg::BIT_IBF] = pspInFull;
          rVal[bnk1_pkg::BIT_OBF] = pspOutFull;
        end
        bnk1_pkg::IDX_TX_CTRL[4:0]: begin
          rVal = rawVal;
          rVal[bnk1_pkg::BIT_TRMT] = txShiftEmpty;
        end
        default: begin
          rVal = rawVal;
        end
      endcase
    end
  end

  always_comb begin
    rdState_next = rdState_reg;
    rData_next = rData_reg;
    case (rdState_reg)
      bnk1_pkg::RD_IDLE: begin
        if (s_axi_arvalid) begin
          rData_next = rVal;
          rdState_next = bnk1_pkg::RD_DATA;
        end
      end
      bnk1_pkg::RD_DATA: begin
        if (s_axi_rready) begin
          rdState_next = bnk1_pkg::RD_IDLE;
        end
      end
      default: begin
        rdState_next = bnk1_pkg::RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdState_reg <= bnk1_pkg::RD_IDLE;
      rData_reg <= 8'h00;
    end else begin
      rdState_reg <= rdState_next;
      rData_reg <= rData_next;
    end
  end

  // ---------------------------------------------------------------
  // configuration outputs
  // ---------------------------------------------------------------
  assign cfg.option = mem_reg[bnk1_pkg::IDX_OPTION[4:0]];
  assign cfg.status = mem_reg[bnk1_pkg::IDX_STATUS[4:0]];
  assign cfg.pointer = mem_reg[bnk1_pkg::IDX_POINTER[4:0]];
  assign cfg.dirA = mem_reg[bnk1_pkg::IDX_DIR_A[4:0]];
  assign cfg.dirB = mem_reg[bnk1_pkg::IDX_DIR_B[4:0]];
  assign cfg.dirC = mem_reg[bnk1_pkg::IDX_DIR_C[4:0]];
  assign cfg.dirD = mem_reg[bnk1_pkg::IDX_DIR_D[4:0]];
  assign cfg.dirE = mem_reg[bnk1_pkg::IDX_DIR_E[4:0]];
  assign cfg.pcLatch = mem_reg[bnk1_pkg::IDX_PCLATCH[4:0]];
  assign cfg.intCtl = mem_reg[bnk1_pkg::IDX_INTCTL[4:0]];
  assign cfg.pieOne = mem_reg[bnk1_pkg::IDX_PIE_ONE[4:0]];
  assign cfg.pieTwo = mem_reg[bnk1_pkg::IDX_PIE_TWO[4:0]];
  assign cfg.power = mem_reg[bnk1_pkg::IDX_POWER[4:0]];
  assign cfg.t2Period = mem_reg[bnk1_pkg::IDX_T2PERIOD[4:0]];
  assign cfg.sspAddr = mem_reg[bnk1_pkg::IDX_SSP_ADDR[4:0]];
  assign cfg.txCtrl = mem_reg[bnk1_pkg::IDX_TX_CTRL[4:0]];
  assign cfg.baud = mem_reg[bnk1_pkg::IDX_BAUD[4:0]];
endmodule : bnk1_sfr_bank
`default_nettype wire

/* File: sim/bnk1_sfr_bank_props.sv */
// Purpose: concurrent checks on the bank-one register file ports
// Assumes: one clock domain, rst asynchronous active high
// Notes: bound into every instance of the register file
`timescale 1ns/1ps
`default_nettype none
module bnk1_sfr_bank_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic extResetPulse,
  input wire logic wdtResetPulse,
  input wire logic pcLoad,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire bnk1_pkg::bnk1_cfg_t cfg,
  input wire logic [bnk1_pkg::PCU_W-1:0] pcUpper
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_pc_load;
    pcLoad && !extResetPulse && !wdtResetPulse |=> pcUpper == $past(cfg.pcLatch[4:0]);
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("upper counter not loaded from latch");
  property p_rst_pcu;
    extResetPulse || wdtResetPulse |=> pcUpper == 5'h00;
  endproperty
  a_rst_pcu: assert property (p_rst_pcu) else $error("upper counter not cleared");
  property p_ext_keep;
    extResetPulse |=> cfg.pointer == $past(cfg.pointer) && cfg.power == $past(cfg.power);
  endproperty
  a_ext_keep: assert property (p_ext_keep) else $error("kept field lost on pin reset");
  property p_ext_vals;
    extResetPulse |=> cfg.option == 8'hff && cfg.dirA == 8'h3f && cfg.status[7:5] == 3'h0;
  endproperty
  a_ext_vals: assert property (p_ext_vals) else $error("pin reset values wrong");
  property p_wdt_to;
    wdtResetPulse |=> !cfg.status[4] && cfg.status[3] == $past(cfg.status[3]);
  endproperty
  a_wdt_to: assert property (p_wdt_to) else $error("watchdog status bits wrong");
  property p_latch_bits;
    cfg.pcLatch[7:5] == 3'h0 && cfg.dirA[7:6] == 2'h0;
  endproperty
  a_latch_bits: assert property (p_latch_bits) else $error("absent bits set");
  property p_small_bits;
    cfg.pieTwo[7:1] == 7'h00 && cfg.power[7:2] == 6'h00;
  endproperty
  a_small_bits: assert property (p_small_bits) else $error("absent bits set");
  property p_rdata_hi;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000;
  endproperty
  a_rdata_hi: assert property (p_rdata_hi) else $error("upper read lanes not zero");
  property p_read_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read_lat: assert property (p_read_lat) else $error("read answer late");
  c_pc_load: cover property (pcLoad);
  c_ext: cover property (extResetPulse);
  c_wdt: cover property (wdtResetPulse);
endmodule : bnk1_sfr_bank_props
bind bnk1_sfr_bank bnk1_sfr_bank_props props_u (.clk(clk), .rst(rst),
  .extResetPulse(extResetPulse), .wdtResetPulse(wdtResetPulse), .pcLoad(pcLoad),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .cfg(cfg), .pcUpper(pcUpper));
`default_nettype wire

/* File: sim/bnk1_special_register_map_bench.sv */
// Purpose: self-checking bench for the bank-one register file
// Assumes: AXI4-Lite master sampled at the falling edge, driven at the rising
// Notes: readies are combinational from state, so the falling edge sees them settled
`timescale 1ns/1ps
`default_nettype none
module bnk1_special_register_map_bench;
  logic clk, rst, extResetPulse, wdtResetPulse, pcLoad;
  logic [7:0] indirRdData;
  logic [9:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, rdSeen;
  logic [3:0] wstrb;
  logic pspIn, pspOut, pspOvf, txEmpty, indirStb;
  logic [5:0] serial_port_status;
  logic [1:0] bresp, rresp;
  logic [7:0] indirDat;
  int stbCount = 0;
  bnk1_pkg::bnk1_cfg_t cfg;
  logic [4:0] pcUpper;
  int failCount = 0;
  int nCompared = 0;
  bnk1_sfr_bank dut_u (.clk(clk), .rst(rst), .extResetPulse(extResetPulse),
    .wdtResetPulse(wdtResetPulse), .pcLoad(pcLoad), .indirRdData(indirRdData),
    .pspInFull(pspIn), .pspOutFull(pspOut), .pspOverflowEvt(pspOvf), .sspStatusIn(serial_port_status),
    .txShiftEmpty(txEmpty), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .cfg(cfg), .pcUpper(pcUpper), .indirWrStrobe(indirStb),
    .indirWrData(indirDat));
  // strobe is one cycle wide, so it is counted rather than sampled
  always @(posedge clk) begin
    if (indirStb === 1'b1) stbCount <= stbCount + 1;
  end
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      failCount++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic awT, wT, bT;
    logic [1:0] rsp;
    bT = 1'b0;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bT) begin
      @(negedge clk);
      awT = awvalid & awready;
      wT = wvalid & wready;
      bT = bvalid;
      rsp = bresp;
      @(posedge clk);
      if (awT) awvalid <= 1'b0;
      if (wT) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk({30'h0000_0000, rsp}, 32'h0000_0000);
  endtask : wr
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    logic aT, rT;
    logic [1:0] rsp;
    rT = 1'b0;
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rT) begin
      @(negedge clk);
      aT = arvalid & arready;
      rT = rvalid;
      rdSeen = rdata;
      rsp = rresp;
      @(posedge clk);
      if (aT) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk({30'h0000_0000, rsp}, 32'h0000_0000);
    chk(rdSeen, {24'h00_0000, exp});
  endtask : rdchk
  task automatic pulse(input int which);
    @(posedge clk);
    if (which == 0) extResetPulse <= 1'b1;
    else if (which == 1) wdtResetPulse <= 1'b1;
    else pcLoad <= 1'b1;
    @(posedge clk);
    {extResetPulse, wdtResetPulse, pcLoad} <= 3'h0;
    @(negedge clk);
  endtask : pulse
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_vals();
    logic [7:0] idx [9] = '{8'h81, 8'h83, 8'h85, 8'h86, 8'h89, 8'h92, 8'h98, 8'h93, 8'h8e};
    logic [7:0] exp [9] = '{8'hff, 8'h18, 8'h3f, 8'hff, 8'h07, 8'hff, 8'h02, 8'h00, 8'h00};
    for (int i = 0; i < 9; i++) rdchk(idx[i], exp[i]);
  endtask : t_reset_vals
  task automatic t_unmapped();
    wr(8'h8f, 8'hff);
    rdchk(8'h8f, 8'h00);
    rdchk(8'h9f, 8'h00);
    rdchk(8'h01, 8'h00);
    wstrb <= 4'he;
    wr(8'h92, 8'h00);
    wstrb <= 4'hf;
    rdchk(8'h92, 8'hff);
  endtask : t_unmapped
  task automatic t_bits();
    wr(8'h85, 8'hff);
    rdchk(8'h85, 8'h3f);
    wr(8'h8d, 8'hff);
    rdchk(8'h8d, 8'h01);
    wr(8'h98, 8'hff);
    rdchk(8'h98, 8'hf7);
    wr(8'h8c, 8'hbf);
    rdchk(8'h8c, 8'hbf);
  endtask : t_bits
  task automatic t_psp();
    // overflow event lands on the same edge as the bus clear
    fork
      wr(8'h89, 8'h07);
      begin
        repeat (2) @(posedge clk);
        pspOvf <= 1'b1;
        @(posedge clk);
        pspOvf <= 1'b0;
      end
    join
    rdchk(8'h89, 8'h27);
    wr(8'h89, 8'h07);
    rdchk(8'h89, 8'h07);
    {pspIn, pspOut, txEmpty} <= 3'h6;
    serial_port_status <= 6'h3f;
    rdchk(8'h89, 8'hc7);
    rdchk(8'h94, 8'h3f);
    rdchk(8'h98, 8'hf5);
  endtask : t_psp
  task automatic t_common();
    wr(8'h84, 8'ha5);
    rdchk(8'h04, 8'ha5);
    wr(8'h0b, 8'h3c);
    rdchk(8'h8b, 8'h3c);
    rdchk(8'h00, 8'h5a);
    wr(8'h00, 8'h3c);
    @(negedge clk);
    chk(stbCount, 32'h0000_0001);
    chk({24'h00_0000, indirDat}, 32'h0000_003c);
  endtask : t_common
  task automatic t_upper_pc();
    wr(8'h8a, 8'hf5);
    rdchk(8'h0a, 8'h15);
    pulse(2);
    chk({27'h000_0000, pcUpper}, 32'h0000_0015);
    wr(8'h8a, 8'h0a);
    wr(8'h82, 8'h12);
    @(negedge clk);
    chk({27'h000_0000, pcUpper}, 32'h0000_000a);
  endtask : t_upper_pc
  task automatic t_other_resets();
    wr(8'h81, 8'h00);
    wr(8'h84, 8'haa);
    wr(8'h8e, 8'h03);
    wr(8'h03, 8'h07);
    pulse(0);
    chk({27'h000_0000, pcUpper}, 32'h0000_0000);
    rdchk(8'h81, 8'hff);
    rdchk(8'h84, 8'haa);
    rdchk(8'h8e, 8'h03);
    rdchk(8'h83, 8'h1f);
    pulse(1);
    rdchk(8'h83, 8'h0f);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdchk(8'h84, 8'h00);
    rdchk(8'h8e, 8'h00);
  endtask : t_other_resets
  task automatic summarize();
    $display("compared %0d, mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  initial begin
    rst = 1'b1;
    {extResetPulse, wdtResetPulse, pcLoad, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    indirRdData = 8'h5a;
    {pspIn, pspOut, pspOvf, txEmpty} = 4'h1;
    serial_port_status = 6'h00;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset_vals();
    t_unmapped();
    t_bits();
    t_psp();
    t_common();
    t_upper_pc();
    t_other_resets();
    summarize();
  end
  // a hung handshake would otherwise stall the run forever
  initial begin
    repeat (20000) @(posedge clk);
    failCount++;
    summarize();
  end
endmodule : bnk1_special_register_map_bench
`default_nettype wire
